// >>> include/pmcc_consts.vh
// Constants for the performance-monitor counter control block.
// Assumes inclusion by the core file only; values are bit positions and encodings.
`ifndef PMCC_CONSTS_VH
`define PMCC_CONSTS_VH

// ****************************************
// System register selectors
// ****************************************
`define PMCC_SEL_W          2
`define PMCC_SEL_NONE       2'h0
`define PMCC_SEL_CONTROL    2'h1
`define PMCC_SEL_PRESENCE   2'h2
`define PMCC_SEL_MACHINE_ID 2'h3

// Machine id encoding: op0, CRn, op1, op2, CRm
`define PMCC_MID_OP0        2'h3
`define PMCC_MID_CRN        4'hf
`define PMCC_MID_OP1        3'h0
`define PMCC_MID_OP2        3'he
`define PMCC_MID_CRM        4'h6

// ****************************************
// Control register fields
// ****************************************
`define PMCC_MAKER_HI       31
`define PMCC_MAKER_LO       24
`define PMCC_PART_HI        23
`define PMCC_PART_LO        16
`define PMCC_QTY_HI         15
`define PMCC_QTY_LO         11
`define PMCC_QTY_VALUE      5'h06
`define PMCC_LC_BIT         6
`define PMCC_DP_BIT         5
`define PMCC_X_BIT          4
`define PMCC_D_BIT          3
`define PMCC_C_BIT          2
`define PMCC_P_BIT          1
`define PMCC_E_BIT          0

// ****************************************
// Event presence map, upper word
// ****************************************
`define PMCC_PRESENCE_UPPER 64'h0000_0000_fef2_ae7f

// ****************************************
// Counters
// ****************************************
`define PMCC_NUM_EVENT      6
`define PMCC_EVT_W          32
`define PMCC_PRESCALE_W     6
`define PMCC_PRESCALE_LAST  6'h3f

`endif

// >>> core/pmcc_control.v
// Performance-monitor control register, event presence map and cycle counter.
// Assumes a system-register access port in the core clock domain, one access a cycle.
//
// Notes on behaviour
// - Presence bit 23 reads one, bit 24 reads zero.
// - Presence bits 11 to 9 read one, bits 8 and 7 read zero.
// - Maker code in 31:24, part code in 23:16, read-only.
// - Counter quantity field 15:11 reads six counters.
// - Overflow from bit 31 when long-cycle select is 0, else bit 63.
// - Debug-prohibit gate set stops cycle counter unless debug permitted and enabled.
// - Export bit enables event export; resets to zero.
// - Export bit has no effect on the interrupt output.
// - Divider clear counts every cycle; set counts once per 64 cycles.
// - Writing one to bit 2 clears the cycle counter, not its overflow flag.
// - Writing one to bit 1 clears event counters, not the cycle counter.
// - Low-level non-secure reset spares counters reserved for the hypervisor.
// - Event counter reset leaves overflow flags unchanged.
// - Global enable bit gates all counters except hypervisor-reserved ones at low-level non-secure; read/write, resets to zero.
// - Low-level non-secure enable does not touch hypervisor-reserved counters.
// - Warm reset clears the global enable bit.
// - Machine id register read by op0 3, CRn 15, op1 0, op2 6 (3'he truncates to 3 bits), CRm 6.
`include "pmcc_consts.vh"

module pmcc_control #(
  parameter [7:0]  MAKER_CODE = 8'h5a,               // Arbitrary value
  parameter [7:0]  PART_CODE  = 8'h3c,               // Arbitrary value
  parameter [63:0] MACHINE_ID = 64'h0000_0000_0000_0000
)(
  input  wire        clock,
  input  wire        rst_b,
  input  wire        sr_write,
  input  wire        sr_read,
  input  wire [1:0]  sr_select,
  input  wire [1:0]  sr_op0,
  input  wire [3:0]  sr_crn,
  input  wire [2:0]  sr_op1,
  input  wire [2:0]  sr_op2,
  input  wire [3:0]  sr_crm,
  input  wire [31:0] sr_wdata,
  input  wire        low_el_nonsecure,
  input  wire [4:0]  hyp_counter_partition,
  input  wire        debug_permitted,
  input  wire        debug_enabled,
  input  wire [5:0]  event_enable,
  input  wire [5:0]  event_pulse,
  output reg  [63:0] sr_rdata,
  output reg         sr_rvalid,
  output reg         export_enable,
  output reg  [5:0]  export_events,
  output reg         cycle_overflow_set,
  output reg  [63:0] cycle_counter,
  output reg  [191:0] event_counts
);

  // ****************************************
  // Helpers
  // ****************************************
  // Counters at or above the partition belong to the hypervisor
  function guest_owned;
    input integer idx;
    input [4:0]   part;
    begin
      guest_owned = (idx < part);
    end
  endfunction

  // Read image of the control register with the fixed fields in place
  function [31:0] control_image;
    input [3:0] rw_bits;
    begin
      control_image = {MAKER_CODE, PART_CODE, `PMCC_QTY_VALUE, 4'h0, rw_bits, 3'h0};
    end
  endfunction

  // Encoding of the machine identification register read
  function is_machine_id;
    input [1:0] op0;
    input [3:0] crn;
    input [2:0] op1;
    input [2:0] op2;
    input [3:0] crm;
    begin
      is_machine_id = (op0 == `PMCC_MID_OP0) && (crn == `PMCC_MID_CRN) && (op1 == `PMCC_MID_OP1)
                      && (op2 == `PMCC_MID_OP2) && (crm == `PMCC_MID_CRM);
    end
  endfunction

  // Overflow when the selected bit falls from one to zero on an increment
  function wraps;
    input [63:0] old_count;
    input [63:0] new_count;
    input        long_sel;
    begin
      if (long_sel)
        wraps = old_count[63] && !new_count[63];
      else
        wraps = old_count[31] && !new_count[31];
    end
  endfunction

  // ****************************************
  // Control bits
  // ****************************************
  reg                          long_cycle_overflow_select;
  reg                          debug_prohibit_cycle_gate;
  reg                          divide_by_64;
  reg                          global_enable;
  reg [`PMCC_PRESCALE_W-1:0]   prescale;
  reg [`PMCC_EVT_W-1:0]        evt [0:`PMCC_NUM_EVENT-1];
  reg                          mid_hit;
  reg                          cycle_step;
  reg                          cycle_run;
  reg [63:0]                   next_cycle;
  integer                      i;
  integer                      j;
  reg [2:0]                    permit_sync;
  reg [2:0]                    enable_sync;
  reg                          debug_permit_ok;
  reg                          debug_enable_ok;
  reg [`PMCC_NUM_EVENT-1:0]    evt_clear;
  reg [`PMCC_NUM_EVENT-1:0]    evt_step;

  wire ctl_wr  = sr_write && (sr_select == `PMCC_SEL_CONTROL);
  // Counter resets act on the write itself; nothing stores them, so they read zero
  wire clr_cyc = ctl_wr && sr_wdata[`PMCC_C_BIT];
  wire clr_evt = ctl_wr && sr_wdata[`PMCC_P_BIT];

  always @*
  begin
    mid_hit = is_machine_id(sr_op0, sr_crn, sr_op1, sr_op2, sr_crm);
    cycle_run = global_enable && !(debug_prohibit_cycle_gate && !(debug_permit_ok && debug_enable_ok));
    cycle_step = cycle_run && (!divide_by_64 || (prescale == `PMCC_PRESCALE_LAST));
    next_cycle = cycle_counter + 64'h1;
  end

  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      long_cycle_overflow_select <= 1'b0;
      debug_prohibit_cycle_gate  <= 1'b0;
      export_enable              <= 1'b0;
      divide_by_64               <= 1'b0;
      global_enable              <= 1'b0;
    end
    else if (ctl_wr)
    begin
      long_cycle_overflow_select <= sr_wdata[`PMCC_LC_BIT];
      debug_prohibit_cycle_gate  <= sr_wdata[`PMCC_DP_BIT];
      export_enable              <= sr_wdata[`PMCC_X_BIT];
      divide_by_64               <= sr_wdata[`PMCC_D_BIT];
      global_enable              <= sr_wdata[`PMCC_E_BIT];
    end
  end

  // ****************************************
  // Debug authentication synchroniser
  // ****************************************
  // Levels come from outside the core clock; take a change once stages two and three agree
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      permit_sync     <= 3'h0;
      enable_sync     <= 3'h0;
      debug_permit_ok <= 1'b0;
      debug_enable_ok <= 1'b0;
    end
    else
    begin
      permit_sync <= {permit_sync[1:0], debug_permitted};
      enable_sync <= {enable_sync[1:0], debug_enabled};
      if (permit_sync[1] == permit_sync[2])
        debug_permit_ok <= permit_sync[2];
      if (enable_sync[1] == enable_sync[2])
        debug_enable_ok <= enable_sync[2];
    end
  end

  // ****************************************
  // Cycle counter and prescaler
  // ****************************************
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      prescale           <= 6'h00;
      cycle_counter      <= 64'h0;
      cycle_overflow_set <= 1'b0;
    end
    else
    begin
      // Held clear while stopped so the first divided count comes 64 cycles after enabling
      if (!cycle_run)
        prescale <= 6'h00;
      else
        prescale <= prescale + 6'h01;
      // Overflow pulse is not raised by the clear path
      cycle_overflow_set <= 1'b0;
      if (clr_cyc)
        cycle_counter <= 64'h0;
      else if (cycle_step)
      begin
        cycle_counter <= next_cycle;
        cycle_overflow_set <= wraps(cycle_counter, next_cycle, long_cycle_overflow_select);
      end
    end
  end

  // ****************************************
  // Event counters
  // ****************************************
  // A reset write wins over an event in the same cycle
  always @*
  begin
    evt_clear = {`PMCC_NUM_EVENT{1'b0}};
    evt_step  = {`PMCC_NUM_EVENT{1'b0}};
    for (j = 0; j < `PMCC_NUM_EVENT; j = j + 1)
    begin
      evt_clear[j] = clr_evt && (!low_el_nonsecure || guest_owned(j, hyp_counter_partition));
      evt_step[j]  = !evt_clear[j] && event_enable[j] && event_pulse[j]
                     && (global_enable || (low_el_nonsecure && !guest_owned(j, hyp_counter_partition)));
    end
  end

  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      for (i = 0; i < `PMCC_NUM_EVENT; i = i + 1)
        evt[i] <= 32'h0;
    end
    else
    begin
      for (i = 0; i < `PMCC_NUM_EVENT; i = i + 1)
      begin
        // Overflow flags live elsewhere and are never touched here
        if (evt_clear[i])
          evt[i] <= 32'h0;
        else if (evt_step[i])
          evt[i] <= evt[i] + 32'h1;
      end
    end
  end

  always @(posedge clock)
  begin
    // Snapshot one cycle behind the counters so all six change together
    if (!rst_b)
      event_counts <= 192'h0;
    else
      event_counts <= {evt[5], evt[4], evt[3], evt[2], evt[1], evt[0]};
  end

  // ****************************************
  // Event export, independent of interrupts
  // ****************************************
  always @(posedge clock)
  begin
    if (!rst_b)
      export_events <= 6'h00;
    else
      export_events <= export_enable ? event_pulse : 6'h00;
  end

  // ****************************************
  // Read path
  // ****************************************
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      sr_rdata  <= 64'h0;
      sr_rvalid <= 1'b0;
    end
    else
    begin
      sr_rvalid <= sr_read;
      if (!sr_read)
        sr_rdata <= 64'h0;
      // The machine id encoding takes priority over the selector
      else if (mid_hit)
        sr_rdata <= MACHINE_ID;
      else
      begin
        case (sr_select)
          `PMCC_SEL_CONTROL:
            sr_rdata <= {32'h0, control_image({long_cycle_overflow_select, debug_prohibit_cycle_gate,
                                               export_enable, divide_by_64}) | {31'h0, global_enable}};
          `PMCC_SEL_PRESENCE:
            sr_rdata <= `PMCC_PRESENCE_UPPER;
          default:
            sr_rdata <= 64'h0;
        endcase
      end
    end
  end

endmodule

// >>> bench/pmcc_control_assertions.sv
// Checker for the counter control block.
// Assumes binding to pmcc_control; watches its ports only.
module pmcc_checker (
  input logic         clock,
  input logic         rst_b,
  input logic         sr_write,
  input logic         sr_read,
  input logic [1:0]   sr_select,
  input logic [1:0]   sr_op0,
  input logic [31:0]  sr_wdata,
  input logic         low_el_nonsecure,
  input logic [63:0]  sr_rdata,
  input logic         sr_rvalid,
  input logic         export_enable,
  input logic [5:0]   export_events,
  input logic         cycle_overflow_set,
  input logic [63:0]  cycle_counter,
  input logic [191:0] event_counts
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  wire ctl_wr = sr_write && sr_select == 2'h1;
  wire rd_ctl = sr_read && sr_select == 2'h1 && sr_op0 == 2'h0;
  wire rd_map = sr_read && sr_select == 2'h2 && sr_op0 == 2'h0;
  sequence s_stop;
    ctl_wr && sr_wdata[2:0] == 3'h0 ##1 !sr_write;
  endsequence
  a_read_answer: assert property (sr_read |=> sr_rvalid) else $error("read not answered");
  a_idle_quiet: assert property (!sr_read |=> !sr_rvalid && sr_rdata == 64'h0) else $error("read data without read");
  a_map_bits: assert property (rd_map |=> sr_rdata[24:23] == 2'b01 && sr_rdata[11:7] == 5'b11100)
    else $error("presence map bits wrong");
  a_ctl_fixed: assert property (rd_ctl |=> sr_rdata[15:11] == 5'b00110 && sr_rdata[2:1] == 2'h0)
    else $error("control fixed fields wrong");
  a_export_bit: assert property (ctl_wr |=> export_enable == $past(sr_wdata[4]))
    else $error("export bit not stored");
  a_export_quiet: assert property (!export_enable && !$past(export_enable) |-> export_events == 6'h0)
    else $error("events exported while disabled");
  a_stop_hold: assert property (s_stop |=> $stable(cycle_counter))
    else $error("cycle counter runs while disabled");
  a_cycle_clear: assert property (ctl_wr && sr_wdata[2] |-> ##[1:2] cycle_counter <= 64'h1)
    else $error("cycle counter not cleared");
  a_event_clear: assert property (ctl_wr && sr_wdata[1] && !low_el_nonsecure |-> ##[1:3] event_counts == 192'h0)
    else $error("event counters not cleared");
  a_overflow_wrap: assert property (cycle_overflow_set |-> cycle_counter[31:0] == 32'h0)
    else $error("overflow flagged without a wrap");
endmodule

bind pmcc_control pmcc_checker u_chk (.clock(clock), .rst_b(rst_b), .sr_write(sr_write), .sr_read(sr_read),
  .sr_select(sr_select), .sr_op0(sr_op0), .sr_wdata(sr_wdata), .low_el_nonsecure(low_el_nonsecure),
  .sr_rdata(sr_rdata), .sr_rvalid(sr_rvalid), .export_enable(export_enable), .export_events(export_events),
  .cycle_overflow_set(cycle_overflow_set),
  .cycle_counter(cycle_counter), .event_counts(event_counts));

// >>> bench/perf_monitor_counter_control_bench.sv
// Bench for the counter control block.
// Assumes pmcc_control and its checker are compiled first.
module perf_monitor_counter_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clock = 0, rst_b = 0, sr_write = 0, sr_read = 0, low_el_nonsecure = 0;
  logic         debug_permitted = 0, debug_enabled = 0, sr_rvalid, export_enable, cycle_overflow_set;
  logic [1:0]   sr_select = 2'h0, sr_op0 = 2'h0;
  logic [3:0]   sr_crn = 4'h0, sr_crm = 4'h0;
  logic [2:0]   sr_op1 = 3'h0, sr_op2 = 3'h0;
  logic [31:0]  sr_wdata = 32'h0;
  logic [4:0]   hyp_counter_partition = 5'h3;
  logic [5:0]   event_enable = 6'h3f, event_pulse = 6'h0, export_events;
  logic [63:0]  sr_rdata, cycle_counter, c0;
  logic [191:0] event_counts;
  int           fails = 0, comparisons = 0;

  always #5 clock = ~clock;

  // Identity values are arbitrary
  pmcc_control #(.MAKER_CODE(8'h12), .PART_CODE(8'h34), .MACHINE_ID(64'ha5)) uut (.clock(clock), .rst_b(rst_b),
    .sr_write(sr_write), .sr_read(sr_read), .sr_select(sr_select), .sr_op0(sr_op0), .sr_crn(sr_crn),
    .sr_op1(sr_op1), .sr_op2(sr_op2), .sr_crm(sr_crm), .sr_wdata(sr_wdata), .low_el_nonsecure(low_el_nonsecure),
    .hyp_counter_partition(hyp_counter_partition), .debug_permitted(debug_permitted),
    .debug_enabled(debug_enabled), .event_enable(event_enable), .event_pulse(event_pulse), .sr_rdata(sr_rdata),
    .sr_rvalid(sr_rvalid), .export_enable(export_enable), .export_events(export_events),
    .cycle_overflow_set(cycle_overflow_set), .cycle_counter(cycle_counter), .event_counts(event_counts));

  // ****************************************
  // Tasks
  // ****************************************
  task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [31:0] d);
    @(negedge clock);
    sr_write = 1;
    sr_select = 2'h1;
    sr_wdata = d;
    @(negedge clock);
    sr_write = 0;
  endtask
  task rd(input logic [1:0] s, input logic [63:0] m, input logic [63:0] exp, input string what);
    @(negedge clock);
    sr_read = 1;
    sr_select = s;
    @(negedge clock);
    sr_read = 0;
    check(what, sr_rdata & m, exp);
  endtask
  task rate(input int n, input logic [63:0] exp, input string what);
    repeat (4) @(negedge clock);
    c0 = cycle_counter;
    repeat (n) @(negedge clock);
    check(what, cycle_counter - c0, exp);
  endtask
  task pulse(input int n);
    event_pulse = 6'h3f;
    repeat (n) @(negedge clock);
    event_pulse = 6'h0;
    repeat (3) @(negedge clock);
  endtask
  task print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    repeat (8) @(negedge clock);
    rst_b = 1;
    rd(2'h1, '1, 64'h1234_3000, "control reset");
    check("export reset", export_enable, 64'h0);
    rd(2'h2, 64'h0180_0f80, 64'h0080_0e00, "presence");
    {sr_op0, sr_crn, sr_op2, sr_crm} = {2'h3, 4'hf, 3'he, 4'h6};
    rd(2'h0, '1, 64'ha5, "machine id");
    {sr_op0, sr_crn, sr_op2, sr_crm} = 13'h0;
    wr(32'hffff_ffff);
    rd(2'h1, '1, 64'h1234_3079, "control written");
    check("export set", export_enable, 64'h1);
    $display("test registers done");
    wr(32'h0);
    wr(32'h5);
    rate(10, 64'ha, "count every cycle");
    wr(32'h0);
    rate(20, 64'h0, "count disabled");
    wr(32'hd);
    repeat (130) @(negedge clock);
    check("prescaled count", cycle_counter, 64'h2);
    wr(32'h21);
    rate(10, 64'h0, "debug gated");
    debug_permitted = 1;
    debug_enabled = 1;
    rate(10, 64'ha, "debug allowed");
    check("no overflow", cycle_overflow_set, 64'h0);
    $display("test cycle counter done");
    wr(32'h3);
    pulse(5);
    check("event count", event_counts[31:0], 64'h5);
    low_el_nonsecure = 1;
    c0 = cycle_counter;
    wr(32'h3);
    repeat (3) @(negedge clock);
    check("low reset open", event_counts[31:0], 64'h0);
    check("low reset kept", event_counts[191:160], 64'h5);
    check("cycle kept", cycle_counter > c0, 64'h1);
    wr(32'h0);
    pulse(2);
    check("low enable open", event_counts[31:0], 64'h0);
    check("low enable kept", event_counts[191:160], 64'h7);
    low_el_nonsecure = 0;
    wr(32'h2);
    repeat (3) @(negedge clock);
    check("high reset", event_counts[191:160], 64'h0);
    $display("test event counters done");
    wr(32'h11);
    event_pulse = 6'h2d;
    @(negedge clock);
    event_pulse = 6'h0;
    check("export on", export_events, 64'h2d);
    $display("test export done");
    rst_b = 0;
    repeat (2) @(negedge clock);
    rst_b = 1;
    rd(2'h1, '1, 64'h1234_3000, "control warm reset");
    check("export warm reset", export_enable, 64'h0);
    rate(10, 64'h0, "stopped after reset");
    $display("test warm reset done");
    print_verdict;
  end
endmodule
